// file: rtl/ssq_pkg.sv
package ssq_pkg;

    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_ACTION = 7'h70;
    localparam logic [6:0] IDX_MAXIMA = 7'h71;
    localparam logic [6:0] IDX_DELAYS = 7'h72;
    localparam logic [6:0] IDX_PROTO = 7'h73;
    localparam logic [6:0] IDX_LEMASK = 7'h74;
    localparam logic [6:0] IDX_STATUS = 7'h7F;
    localparam logic [6:0] IDX_TEST_LO = 7'h40;
    localparam logic [6:0] IDX_TEST_HI = 7'h6F;

    // Storage slots
    localparam logic [2:0] SLOT_ACTION = 3'h0;
    localparam logic [2:0] SLOT_MAXIMA = 3'h1;
    localparam logic [2:0] SLOT_DELAYS = 3'h2;
    localparam logic [2:0] SLOT_PROTO = 3'h3;
    localparam logic [2:0] SLOT_LEMASK = 3'h4;
    localparam logic [2:0] SLOT_STATUS = 3'h5;
    localparam logic [2:0] SLOT_NONE = 3'h7;
    localparam int NUM_REGS = 5;
    localparam int REG_W = 28;

    // Field positions
    localparam int ACT_W = 3;
    localparam int TRIG_LSB = 6;
    localparam int PMAX_LSB = 0;
    localparam int SMAX_LSB = 13;
    localparam int SYNCM_LSB = 25;
    localparam int PDLY_LSB = 0;
    localparam int PSKIP_BIT = 13;
    localparam int SDLY_LSB = 14;
    localparam int SSKIP_BIT = 27;
    localparam int PROTO_W = 3;
    localparam int GMASK_LSB = 0;
    localparam int SUBM_LSB = 13;
    localparam int LOADPT_BIT = 26;
    localparam int SUBGRP_LSB = 13;

    // Reset values
    localparam logic [27:0] RST_ACTION = 28'h0000000;
    localparam logic [27:0] RST_MAXIMA = 28'h0000000;
    localparam logic [27:0] RST_DELAYS = 28'h0000000;
    localparam logic [27:0] RST_PROTO = 28'h0000000;
    localparam logic [27:0] RST_LEMASK = 28'h4000000;

    typedef enum logic [2:0] {
        ACT_IDLE = 3'b000,
        ACT_SINGLE = 3'b001,
        ACT_REPEAT = 3'b010,
        ACT_DELAYED = 3'b011,
        ACT_DLY_REPEAT = 3'b100,
        ACT_MAN_EXP = 3'b101,
        ACT_MAN_READ = 3'b110,
        ACT_FORCE_IDLE = 3'b111
    } ssq_action_t;

    typedef enum logic [2:0] {
        PR_IDLE = 3'b000,
        PR_MANUAL = 3'b001,
        PR_TEST2 = 3'b010,
        PR_TEST3 = 3'b011,
        PR_MODE = 3'b100,
        PR_PRIMARY = 3'b101,
        PR_SECONDARY = 3'b110,
        PR_KEEP_ON = 3'b111
    } ssq_proto_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DELAY = 3'b001,
        ST_COUNT = 3'b010,
        ST_MAN_EXP = 3'b011,
        ST_MAN_READ = 3'b100
    } ssq_cnt_state_t;

endpackage

// file: rtl/ssq_shutter_gpo.sv
module ssq_shutter_gpo #(
    parameter int ADDR_W = 10,
    parameter int NUM_AUX = 8
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timing pins
    input wire logic field_sync,
    input wire logic line_sync,
    input wire logic sensor_gate_pulse,
    input wire logic mode_count_active,
    // Shutter and auxiliary outputs
    output logic [NUM_AUX-1:0] aux_signal,
    output logic primary_active,
    output logic secondary_active,
    output logic gate_mask,
    output logic substrate_mask,
    output logic field_sync_out,
    output logic line_sync_out
);
    import ssq_pkg::*;

    function automatic logic [2:0] slot_of(input logic [6:0] idx);
        logic [2:0] s;
        s = SLOT_NONE;
        if (idx == IDX_ACTION) begin
            s = SLOT_ACTION;
        end else if (idx == IDX_MAXIMA) begin
            s = SLOT_MAXIMA;
        end else if (idx == IDX_DELAYS) begin
            s = SLOT_DELAYS;
        end else if (idx == IDX_PROTO) begin
            s = SLOT_PROTO;
        end else if (idx == IDX_LEMASK) begin
            s = SLOT_LEMASK;
        end else if (idx == IDX_STATUS) begin
            s = SLOT_STATUS;
        end
        return s;
    endfunction

    function automatic logic proto_out(input logic [2:0] pr,
            input logic trig, input logic mode_on,
            input logic pri_on, input logic sec_on);
        logic o;
        o = 1'b0;
        case (pr)
            PR_MANUAL: o = trig;
            PR_MODE: o = mode_on;
            PR_PRIMARY: o = pri_on;
            PR_SECONDARY: o = sec_on;
            PR_KEEP_ON: o = 1'b1;
            // Test codes drive nothing, like idle
            default: o = 1'b0;
        endcase
        return o;
    endfunction

    // Pin synchronisers: bit 0 field, 1 line, 2 gate, 3 mode
    logic [3:0] meta_q, sync_q, prev_q;
    logic [3:0] meta_d, sync_d, prev_d;
    logic fs_rise, sg_rise;

    always_comb begin
        meta_d = {mode_count_active, sensor_gate_pulse, line_sync,
                  field_sync};
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
            prev_q <= 4'h0;
        end else if (pclk_en) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign fs_rise = sync_q[0] & ~prev_q[0];
    assign sg_rise = sync_q[2] & ~prev_q[2];

    // APB registers: shadow copies written by software, active copies
    // loaded at the field sync rise, the LEMASK substrate group at its own load point
    logic [REG_W-1:0] sh_q [NUM_REGS];
    logic [REG_W-1:0] sh_d [NUM_REGS];
    logic [REG_W-1:0] cfg_q [NUM_REGS];
    logic [REG_W-1:0] cfg_d [NUM_REGS];
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic [6:0] idx;
    logic [2:0] slot;
    logic wr_en, setup, test_hit, sub_load;
    logic [REG_W-1:0] status;

    assign idx = paddr[8:2];
    assign slot = slot_of(idx);
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;
    assign test_hit = (idx >= IDX_TEST_LO) && (idx <= IDX_TEST_HI);
    assign sub_load = cfg_q[SLOT_LEMASK][LOADPT_BIT] ? fs_rise : sg_rise;

    always_comb begin
        sh_d = sh_q;
        cfg_d = cfg_q;
        prdata_d = prdata;
        pready_d = setup;
        pslverr_d = 1'b0;
        if (setup) begin
            prdata_d = 32'h00000000;
            // Test range and holes answer with an error
            if (test_hit || slot == SLOT_NONE) begin
                pslverr_d = 1'b1;
            end else if (slot == SLOT_STATUS) begin
                pslverr_d = pwrite;
                prdata_d = {4'h0, status};
            end else begin
                prdata_d = {4'h0, sh_q[slot]};
            end
        end
        if (wr_en) begin
            sh_d[slot] = pwdata[REG_W-1:0];
        end
        if (fs_rise) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                cfg_d[r] = sh_d[r];
            end
            // Substrate group waits for its own load point
            cfg_d[SLOT_LEMASK][REG_W-1:SUBGRP_LSB] =
                cfg_q[SLOT_LEMASK][REG_W-1:SUBGRP_LSB];
        end
        if (sub_load) begin
            cfg_d[SLOT_LEMASK][REG_W-1:SUBGRP_LSB] =
                sh_d[SLOT_LEMASK][REG_W-1:SUBGRP_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q[SLOT_ACTION] <= RST_ACTION;
            sh_q[SLOT_MAXIMA] <= RST_MAXIMA;
            sh_q[SLOT_DELAYS] <= RST_DELAYS;
            sh_q[SLOT_PROTO] <= RST_PROTO;
            sh_q[SLOT_LEMASK] <= RST_LEMASK;
            cfg_q[SLOT_ACTION] <= RST_ACTION;
            cfg_q[SLOT_MAXIMA] <= RST_MAXIMA;
            cfg_q[SLOT_DELAYS] <= RST_DELAYS;
            cfg_q[SLOT_PROTO] <= RST_PROTO;
            cfg_q[SLOT_LEMASK] <= RST_LEMASK;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (pclk_en) begin
            sh_q <= sh_d;
            cfg_q <= cfg_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // Primary and secondary field counters
    logic [1:0] cnt_on, cnt_start;
    logic [5:0] st_all;

    for (genvar g = 0; g < 2; g++) begin : gen_cnt
        ssq_cnt_state_t st_q, st_d;
        logic [12:0] cnt_q, cnt_d, maxv, dlyv;
        logic done_q, done_d, skip, force_now;
        logic [2:0] act;

        assign act = cfg_q[SLOT_ACTION][g*ACT_W +: ACT_W];
        assign maxv = (g == 0) ? cfg_q[SLOT_MAXIMA][PMAX_LSB +: 13]
                    : {1'b0, cfg_q[SLOT_MAXIMA][SMAX_LSB +: 12]};
        assign dlyv = (g == 0) ? cfg_q[SLOT_DELAYS][PDLY_LSB +: 13]
                    : cfg_q[SLOT_DELAYS][SDLY_LSB +: 13];
        assign skip = (g == 0) ? cfg_q[SLOT_DELAYS][PSKIP_BIT]
                    : cfg_q[SLOT_DELAYS][SSKIP_BIT];
        // Force acts on the written value, not at the next sync
        assign force_now =
            sh_q[SLOT_ACTION][g*ACT_W +: ACT_W] == ACT_FORCE_IDLE;

        always_comb begin
            st_d = st_q;
            cnt_d = cnt_q;
            done_d = done_q;
            if (force_now || act == ACT_FORCE_IDLE) begin
                st_d = ST_IDLE;
                cnt_d = 13'h0000;
            end else if (fs_rise) begin
                case (act)
                    ACT_IDLE: begin
                        st_d = ST_IDLE;
                        cnt_d = 13'h0000;
                        done_d = 1'b0;
                    end
                    ACT_MAN_EXP: begin
                        st_d = ST_MAN_EXP;
                        cnt_d = 13'h0000;
                    end
                    ACT_MAN_READ: begin
                        st_d = ST_MAN_READ;
                        cnt_d = 13'h0000;
                    end
                    default: begin
                        case (st_q)
                            ST_DELAY: begin
                                if (cnt_q + 13'h0001 >= dlyv) begin
                                    st_d = ST_COUNT;
                                    cnt_d = 13'h0000;
                                end else begin
                                    cnt_d = cnt_q + 13'h0001;
                                end
                            end
                            ST_COUNT: begin
                                if (cnt_q < maxv) begin
                                    cnt_d = cnt_q + 13'h0001;
                                end else if (act == ACT_REPEAT) begin
                                    cnt_d = 13'h0000;
                                end else if (act == ACT_DLY_REPEAT) begin
                                    cnt_d = 13'h0000;
                                    if (!skip && dlyv != 13'h0000) begin
                                        st_d = ST_DELAY;
                                    end
                                end else begin
                                    st_d = ST_IDLE;
                                    cnt_d = 13'h0000;
                                    done_d = 1'b1;
                                end
                            end
                            default: begin
                                // One shot waits for action 0 to rearm
                                if (!done_q) begin
                                    cnt_d = 13'h0000;
                                    if ((act == ACT_DELAYED ||
                                         act == ACT_DLY_REPEAT) &&
                                        dlyv != 13'h0000) begin
                                        st_d = ST_DELAY;
                                    end else begin
                                        st_d = ST_COUNT;
                                    end
                                end else begin
                                    st_d = ST_IDLE;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_q <= ST_IDLE;
                cnt_q <= 13'h0000;
                done_q <= 1'b0;
            end else if (pclk_en) begin
                st_q <= st_d;
                cnt_q <= cnt_d;
                done_q <= done_d;
            end
        end

        assign cnt_on[g] = (st_q == ST_COUNT) || (st_q == ST_MAN_EXP)
                         || (st_q == ST_MAN_READ);
        assign cnt_start[g] = fs_rise && (st_d == ST_COUNT)
                            && (cnt_d == 13'h0000);
        assign st_all[g*3 +: 3] = st_q;
    end

    // Long exposure masks, started each time the primary counter enters or restarts ST_COUNT, not by manual exposure
    logic [12:0] gate_left_q, gate_left_d, sub_left_q, sub_left_d;

    always_comb begin
        gate_left_d = gate_left_q;
        sub_left_d = sub_left_q;
        if (cnt_start[0]) begin
            gate_left_d = cfg_q[SLOT_LEMASK][GMASK_LSB +: 13];
            sub_left_d = cfg_q[SLOT_LEMASK][SUBM_LSB +: 13];
        end else begin
            if (fs_rise && gate_left_q != 13'h0000) begin
                gate_left_d = gate_left_q - 13'h0001;
            end
            if (fs_rise && sub_left_q != 13'h0000) begin
                sub_left_d = sub_left_q - 13'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_left_q <= 13'h0000;
            sub_left_q <= 13'h0000;
        end else if (pclk_en) begin
            gate_left_q <= gate_left_d;
            sub_left_q <= sub_left_d;
        end
    end

    assign status = {9'h000, sub_left_q != 13'h0000,
                     gate_left_q != 13'h0000, st_all, cnt_on,
                     sync_q[3], aux_signal};

    // Registered outputs
    logic [NUM_AUX-1:0] aux_d;
    logic [2:0] smask;
    logic busy, fs_out_d, ls_out_d;

    assign smask = cfg_q[SLOT_MAXIMA][SYNCM_LSB +: 3];
    assign busy = cnt_on[0] | (smask[2] & cnt_on[1]);

    always_comb begin
        aux_d = '0;
        for (int i = 0; i < NUM_AUX; i++) begin
            aux_d[i] = proto_out(
                cfg_q[SLOT_PROTO][i*PROTO_W +: PROTO_W],
                cfg_q[SLOT_ACTION][TRIG_LSB + i],
                sync_q[3], cnt_on[0], cnt_on[1]);
        end
        fs_out_d = sync_q[0] & ~(smask[0] & busy);
        ls_out_d = sync_q[1] & ~(smask[1] & busy);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_signal <= '0;
            primary_active <= 1'b0;
            secondary_active <= 1'b0;
            gate_mask <= 1'b0;
            substrate_mask <= 1'b0;
            field_sync_out <= 1'b0;
            line_sync_out <= 1'b0;
        end else if (pclk_en) begin
            aux_signal <= aux_d;
            primary_active <= cnt_on[0];
            secondary_active <= cnt_on[1];
            gate_mask <= gate_left_q != 13'h0000;
            substrate_mask <= sub_left_q != 13'h0000;
            field_sync_out <= fs_out_d;
            line_sync_out <= ls_out_d;
        end
    end

endmodule

// file: tb/ssq_sensor_model.sv
// Far-side timing source: field and line syncs run free once out of reset
module ssq_sensor_model #(
    parameter int FIELD_CYC = 48
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Timing pins
    output logic field_sync,
    output logic line_sync,
    output logic sensor_gate_pulse,
    output logic mode_count_active
);
    timeunit 1ns;
    timeprecision 1ps;
    int pos;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos <= 0;
            field_sync <= 1'b0;
            line_sync <= 1'b0;
            sensor_gate_pulse <= 1'b0;
            mode_count_active <= 1'b0;
        end else begin
            pos <= (pos == FIELD_CYC - 1) ? 0 : pos + 1;
            field_sync <= pos < 4;
            line_sync <= (pos % 12) < 2;
            sensor_gate_pulse <= pos >= 20 && pos < 22;
            // Mode level flips only with a field start, so it is stable
            // in mid-field samples
            if (pos == 0) begin
                mode_count_active <= ~mode_count_active;
            end
        end
    end
endmodule

// file: tb/ssq_shutter_gpo_sva.sv
module ssq_chk #(
    parameter int ADDR_W = 10,
    parameter int NUM_AUX = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Timing and outputs
    input wire logic field_sync,
    input wire logic line_sync,
    input wire logic [NUM_AUX-1:0] aux_signal,
    input wire logic primary_active,
    input wire logic secondary_active,
    input wire logic gate_mask,
    input wire logic field_sync_out,
    input wire logic line_sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic setup;
    logic [7:0] idx;
    logic fs_q;
    logic [3:0] age_q;
    logic [3:0] age_d;
    assign setup = psel && !penable && pclk_en;
    assign idx = paddr[9:2];
    // Cycles since the field sync pin rose, saturating
    always_comb begin
        age_d = age_q;
        if (field_sync && !fs_q) begin
            age_d = 4'h0;
        end else if (age_q != 4'hF) begin
            age_d = age_q + 4'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_q <= 1'b0;
            age_q <= 4'hF;
        end else begin
            fs_q <= field_sync;
            age_q <= age_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_next: assert property (setup |=> pready)
        else $error("no ready in access cycle");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    chk_test_refused: assert property (
        setup && idx inside {[8'h40:8'h6F]} |=> pslverr && prdata == 32'h0)
        else $error("test range not refused");
    chk_mapped_ok: assert property (
        setup && idx inside {[8'h70:8'h74]} |=> !pslverr)
        else $error("mapped register refused");
    chk_upper_zero: assert property (
        pready && !pwrite |-> prdata[31:28] == 4'h0)
        else $error("bits above register width not zero");
    chk_fsync_pass: assert property (
        $rose(field_sync) && pclk_en && !primary_active && !secondary_active
        |-> ##[2:5] field_sync_out)
        else $error("unmasked field sync lost");
    chk_lsync_pass: assert property (
        $rose(line_sync) && pclk_en && !primary_active && !secondary_active
        |-> ##[2:5] line_sync_out)
        else $error("unmasked line sync lost");
    chk_start_sync: assert property (
        $rose(primary_active) |-> age_q < 4'h8)
        else $error("counter started away from field sync");
    chk_aux_sync: assert property (
        (|(aux_signal & ~$past(aux_signal))) |-> age_q < 4'h8)
        else $error("aux output rose away from field sync");
    chk_gate_count: assert property (
        $rose(gate_mask) |-> ##[0:2] primary_active)
        else $error("gate mask without primary count");
    chk_out_reset: assert property (
        $rose(presetn) |-> aux_signal == '0 && !primary_active && !gate_mask)
        else $error("outputs not cleared by reset");
    cov_refused: cover property (pready && pslverr);
    cov_count: cover property ($rose(primary_active));
    cov_gate: cover property ($fell(gate_mask));
    cov_all_on: cover property (aux_signal == '1);
endmodule

bind ssq_shutter_gpo ssq_chk #(.ADDR_W(ADDR_W), .NUM_AUX(NUM_AUX))
    u_ssq_chk (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .field_sync(field_sync),
    .line_sync(line_sync), .aux_signal(aux_signal),
    .primary_active(primary_active),
    .secondary_active(secondary_active), .gate_mask(gate_mask),
    .field_sync_out(field_sync_out), .line_sync_out(line_sync_out)
);

// file: tb/ssq_shutter_gpo_test.sv
module ssq_shutter_gpo_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic field_sync, line_sync, sensor_gate_pulse, mode_count_active;
    logic [7:0] aux_signal, trg, prev;
    logic primary_active, secondary_active, gate_mask, substrate_mask;
    logic field_sync_out, line_sync_out;
    logic [23:0] pr;
    logic [2:0] pa, sa;
    logic [2:0] pok [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [2:0] aok [4] = '{3'h0, 3'h2, 3'h5, 3'h6};
    int cs [5] = '{1, 2, 3, 4, 4};
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'hC266;
    int i, k, r, f1;

    ssq_shutter_gpo u_ssq_shutter_gpo (
        .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .field_sync(field_sync), .line_sync(line_sync),
        .sensor_gate_pulse(sensor_gate_pulse),
        .mode_count_active(mode_count_active), .aux_signal(aux_signal),
        .primary_active(primary_active), .secondary_active(secondary_active),
        .gate_mask(gate_mask), .substrate_mask(substrate_mask),
        .field_sync_out(field_sync_out), .line_sync_out(line_sync_out)
    );
    ssq_sensor_model u_ssq_sensor_model (
        .pclk(pclk), .presetn(presetn), .field_sync(field_sync),
        .line_sync(line_sync), .sensor_gate_pulse(sensor_gate_pulse),
        .mode_count_active(mode_count_active)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic acc(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, input logic [31:0] exp,
                       input logic bad);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        check(32'(pslverr), 32'(bad), "response");
        if (!wr) check(prdata, exp, "read data");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Samples land mid-field, well clear of staging and output lag
    task automatic next_field();
        @(posedge field_sync);
        repeat (12) @(posedge pclk);
    endtask

    function automatic logic [15:0] pat(int mx, int dly, bit rep, bit skp);
        int j, c, per;
        per = !rep ? 99 : (skp ? mx + 1 : mx + 1 + dly);
        pat = 16'h0000;
        c = 0;
        for (j = 0; j < 16; j++) begin
            pat[j] = c <= mx;
            c = (c + 1) % per;
        end
    endfunction

    function automatic logic [7:0] exp_aux(input logic [23:0] p,
        input logic [7:0] t, input logic m, input logic po, input logic so);
        int j;
        exp_aux = 8'h00;
        for (j = 0; j < 8; j++) begin
            case (p[3*j +: 3])
                3'h1: exp_aux[j] = t[j];
                3'h4: exp_aux[j] = m;
                3'h5: exp_aux[j] = po;
                3'h6: exp_aux[j] = so;
                3'h7: exp_aux[j] = 1'b1;
                default: exp_aux[j] = 1'b0;
            endcase
        end
    endfunction

    task automatic run_case(input int a, input int mx, input int dly,
                            input logic skp, inout int fb);
        logic [23:0] tp, ts;
        logic [15:0] e;
        int j, f, ng, ns;
        acc(1, 8'h70, 0, 0, 0);
        // Quiet fields rearm a single shot and drain both masks
        repeat (6) next_field();
        acc(1, 8'h71, (mx << 13) | mx, 0, 0);
        acc(1, 8'h72, {skp, 13'(dly), skp, 13'(dly)}, 0, 0);
        acc(1, 8'h70, (a << 3) | a, 0, 0);
        ng = 0;
        ns = 0;
        for (j = 0; j < 24; j++) begin
            next_field();
            tp[j] = primary_active;
            ts[j] = secondary_active;
            ng += gate_mask;
            ns += substrate_mask;
        end
        f = 0;
        while (f < 16 && tp[f] !== 1'b1) f++;
        if (a == 1) fb = f;
        e = pat(mx, a == 4 ? dly : 0, a == 2 || a == 4, skp);
        check(f, fb + (a > 2 ? dly : 0), "start field");
        check((tp >> f) & 16'hFFFF, e, "primary trace");
        check((ts >> f) & 16'hFFFF, e, "secondary trace");
        if (a == 1) begin
            check(ng, 2, "gate mask fields");
            check(ns, 4, "substrate mask fields");
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        close_out();
    end

    initial begin
        presetn = 1'b0;
        pclk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 5; i++) begin
            acc(0, 8'h70 + 8'(i), 0, i == 4 ? 32'h4000000 : 0, 0);
        end
        acc(1, 8'h40, 32'hFFFFFFF, 0, 1);
        acc(0, 8'h6F, 0, 0, 1);
        acc(0, 8'h75, 0, 0, 1);
        acc(1, 8'h7F, 32'h1, 0, 1);
        for (i = 0; i < 5; i++) begin
            v = $random(seed) & (i == 1 ? 32'h1FFFFFF : 32'hFFFFFFF);
            v = v | (i == 3 ? 32'h924924 : 0);
            acc(1, 8'h70 + 8'(i), v, 0, 0);
            acc(0, 8'h70 + 8'(i), 0, v, 0);
        end
        acc(1, 8'h70, 0, 0, 0);
        acc(1, 8'h74, 32'h4008002, 0, 0);
        for (r = 0; r < 8; r++) begin
            for (k = 0; k < 8; k++) begin
                pr[3*k +: 3] = pok[$unsigned($random(seed)) % 6];
                if (r == 0) pr[3*k +: 3] = 3'h7;
            end
            trg = 8'($random(seed));
            pa = aok[$unsigned($random(seed)) % 4];
            sa = aok[$unsigned($random(seed)) % 4];
            acc(1, 8'h73, {8'h00, pr}, 0, 0);
            acc(1, 8'h70, {18'h0, trg, sa, pa}, 0, 0);
            if (r > 0) check(aux_signal, prev, "staged aux");
            next_field();
            next_field();
            prev = exp_aux(pr, trg, mode_count_active, pa != 0, sa != 0);
            check(32'(primary_active), 32'(pa != 0), "primary");
            check(32'(secondary_active), 32'(sa != 0), "second");
            check(aux_signal, prev, "aux");
        end
        for (i = 0; i < 5; i++) begin
            run_case(cs[i], 1 + $unsigned($random(seed)) % 3,
                     1 + $unsigned($random(seed)) % 3, i == 4, f1);
        end
        // Both counters repeat with field and line sync masked
        acc(1, 8'h71, 32'h6002001, 0, 0);
        acc(1, 8'h70, 32'h12, 0, 0);
        next_field();
        next_field();
        @(posedge field_sync);
        repeat (5) @(posedge pclk);
        check(32'(field_sync_out), 0, "masked field");
        check(32'(line_sync_out), 0, "masked line");
        acc(1, 8'h70, 32'h3F, 0, 0);
        repeat (3) @(posedge pclk);
        check(32'(primary_active), 0, "forced idle");
        check(32'(secondary_active), 0, "forced idle");
        // Every aux follows the mode pin; a frozen block must miss a toggle
        acc(1, 8'h73, 32'h924924, 0, 0);
        next_field();
        next_field();
        prev = {8{mode_count_active}};
        check(aux_signal, prev, "mode aux");
        pclk_en <= 1'b0;
        next_field();
        check(aux_signal, prev, "frozen aux");
        // Second field brings the pin back, so no late edge on release
        next_field();
        pclk_en <= 1'b1;
        close_out();
    end
endmodule
